// ---- design/adc_trigger_select_control.v ----
// Digital control of a 12-bit converter: trigger selection, scan engine, results.
// Assumes an analog core that converts on conv_start and answers with conv_done.
//
// Contract
// - Group B trigger field sits at bits 5:0.
// - Group A trigger field sits at bits 13:8.
// - All-ones code means no source, ignore events.
// - Group A code zero starts on pin edge.
// - Codes 1..8 select the eight timer events.
// - Code 9 selects the event link start.
// - Three-bit addition count; zero means single conversion.
// - Average enable reports mean instead of sum.
// - Sixteen ring entries, ring enable, ring pointer.
// - Sampling time registers for 0-8, L, T, O; the engine uses L for every channel above 8, so T and O never apply.
// - Self-test level, mode and enable controls.
// - Group A priority aborts group B, optional rescan.
// - Group A and group B scan-end interrupts.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "adc_trigger_map.vh"
module adc_trigger_select_control (
  // Clock and reset.
  input  wire        clock,
  input  wire        nrst,
  // AXI4-Lite write channels.
  input  wire [8:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  // AXI4-Lite read channels.
  input  wire [8:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  // Start sources.
  input  wire        timer0_compare_a_event,
  input  wire        timer0_compare_b_event,
  input  wire        common_timer_event,
  input  wire        timer0_compare_e_event,
  input  wire        timer0_compare_f_event,
  input  wire        timer4_a_event,
  input  wire        timer4_b_event,
  input  wire        timer4_a_or_b_event,
  input  wire        event_link_start,
  input  wire        external_start_pin_n,
  // Analog core.
  output wire        conv_start,
  output wire        conv_abort,
  output wire [4:0]  conv_channel,
  output wire [7:0]  conv_sample_states,
  output wire [1:0]  selftest_level_select,
  output wire        selftest_mode_select,
  output wire        selftest_enable,
  input  wire        conv_done,
  input  wire [11:0] conv_result,
  // Interrupts.
  output wire        scan_end_irq,
  output wire        group_b_scan_end_irq,
  output wire        irq
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_FIND  = 3'h1;
  localparam [2:0] S_CONV  = 3'h2;
  localparam [2:0] S_WAIT  = 3'h3;
  localparam [2:0] S_STORE = 3'h4;
  localparam [2:0] S_DONE  = 3'h5;

  // Bus handshake state.
  reg        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg        aw_full_q, w_full_q;
  reg [8:0]  awaddr_q;
  reg [31:0] wdata_q, rdata_q;
  reg [3:0]  wstrb_q;
  reg [1:0]  bresp_q, rresp_q;

  // Software registers.
  reg [15:0] trig_q;
  reg [7:0]  acc_ctl_q;
  reg [8:0]  ctl_q;
  reg [26:0] mask_a_q, mask_b_q;
  reg [1:0]  stat_q, ien_q;
  reg        ring_en_q;
  reg [3:0]  ring_ptr_q;
  reg        ring_wrap_q;
  reg [7:0]  samp_q [0:11];
  reg [15:0] res_q  [0:26];
  reg [15:0] ring_q [0:15];

  // Scan engine state.
  reg [2:0]  state_q;
  reg        grp_q, pend_b_q;
  reg [4:0]  ch_q;
  reg [2:0]  rep_q;
  reg [14:0] acc_q;
  reg [26:0] scan_mask_q;
  reg        conv_start_q, conv_abort_q, scan_end_q, gb_end_q, irq_q;
  reg [4:0]  conv_channel_q;
  reg [7:0]  conv_samp_q;

  // Pin synchroniser.
  reg        pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;

  integer i;

  // Register read view, shared by the read channel and the byte-lane merge on writes.
  function [32:0] rd_word;
    input [8:0] a;
    reg [6:0] w;
    reg [6:0] o;
    begin
      w = a[8:2];
      rd_word = {1'b1, 32'h0000_0000};
      o = 7'h00;
      case (w)
        `W_TRIG:     rd_word[15:0] = trig_q;
        `W_ACC:      rd_word[7:0] = acc_ctl_q;
        `W_CTL:      rd_word[7:0] = ctl_q[7:0];
        `W_MASK_A:   rd_word[26:0] = mask_a_q;
        `W_MASK_B:   rd_word[26:0] = mask_b_q;
        `W_STAT:     rd_word[1:0] = stat_q;
        `W_IEN:      rd_word[1:0] = ien_q;
        `W_RING_EN:  rd_word[0] = ring_en_q;
        `W_RING_PTR: rd_word[4:0] = {ring_wrap_q, ring_ptr_q};
        `W_ENGINE:   rd_word[12:0] = {pend_b_q, grp_q, ch_q, 3'h0, state_q};
        default: begin
          if (w >= `W_SAMP && w <= `W_SAMP_END) begin
            o = w - `W_SAMP;
            rd_word[7:0] = samp_q[o[3:0]];
          end else if (w >= `W_RES && w <= `W_RES_END) begin
            o = w - `W_RES;
            rd_word[15:0] = res_q[o[4:0]];
            rd_word[32] = |(`CH_IMPL & (27'h1 << o[4:0]));
          end else if (w >= `W_RING && w <= `W_RING_END) begin
            o = w - `W_RING;
            rd_word[15:0] = ring_q[o[3:0]];
          end else begin
            rd_word[32] = 1'b0;
          end
        end
      endcase
    end
  endfunction

  // Write side: strobes merge new bytes over the present value.
  wire        do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire [32:0] wr_old   = rd_word(awaddr_q);
  wire [31:0] bm       = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wr_val   = (wr_old[31:0] & ~bm) | (wdata_q & bm);
  wire [31:0] wr_ones  = wdata_q & bm;
  wire [6:0]  wr_w     = awaddr_q[8:2];
  wire [6:0]  wr_so    = wr_w - `W_SAMP;
  wire [6:0]  wr_mode  = wr_w;
  wire [32:0] rd_now   = rd_word(araddr);

  // Write and read channels; an answer follows one cycle after both halves are held.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 9'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      rdata_q   <= 32'h0000_0000;
      bresp_q   <= `RESP_OKAY;
      rresp_q   <= `RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_old[32] ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_now[31:0];
        rresp_q   <= rd_now[32] ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Pin passes three stages; a level change counts once stages two and three agree.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q  <= 1'b1;
      pin_s2_q  <= 1'b1;
      pin_s3_q  <= 1'b1;
      pin_lvl_q <= 1'b1;
    end else begin
      pin_s1_q <= external_start_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_lvl_q <= pin_s3_q;
      end
    end
  end

  // The pin is active low, so a falling settled level is the start edge.
  wire pin_edge = pin_lvl_q & ~pin_s3_q & (pin_s2_q == pin_s3_q);

  wire [7:0] tmr_ev = {timer4_a_or_b_event, timer4_b_event, timer4_a_event,
                       timer0_compare_f_event, timer0_compare_e_event,
                       common_timer_event, timer0_compare_b_event, timer0_compare_a_event};
  wire trig_a;
  wire trig_b;

  // Group A may use the pin; group B has no pin code.
  trigger_source_decode #(.ALLOW_EXT(1'b1)) u_dec_a (
    .code         (trig_q[`TRIG_A_MSB:`TRIG_A_LSB]),
    .timer_events (tmr_ev),
    .event_link   (event_link_start),
    .ext_edge     (pin_edge),
    .start        (trig_a)
  );

  trigger_source_decode #(.ALLOW_EXT(1'b0)) u_dec_b (
    .code         (trig_q[`TRIG_B_MSB:`TRIG_B_LSB]),
    .timer_events (tmr_ev),
    .event_link   (event_link_start),
    .ext_edge     (1'b0),
    .start        (trig_b)
  );

  // Start requests and helpers for the engine.
  wire [1:0]  mode     = ctl_q[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire        grp_mode = (mode == `MODE_GROUP);
  wire        sw_start = do_write & (wr_mode == `W_CTL) & wr_ones[`CTL_SWST_BIT];
  wire        req_a    = trig_a | sw_start;
  wire        req_b    = grp_mode & trig_b;
  wire [2:0]  acc_cnt  = acc_ctl_q[`ACC_CNT_MSB:`ACC_CNT_LSB];
  wire [3:0]  n_div    = {1'b0, acc_cnt} + 4'h1;
  wire [14:0] avg_val  = acc_q / {11'h000, n_div};
  wire [15:0] res_val  = {1'b0, acc_ctl_q[`ACC_AVG_BIT] ? avg_val : acc_q};
  wire [1:0]  st_set   = {gb_end_d(state_q, grp_q), sc_end_d(state_q, grp_q)};
  wire [1:0]  st_clr   = (do_write && wr_w == `W_STAT) ? wr_ones[1:0] : 2'h0;
  wire [1:0]  stat_d   = (stat_q & ~st_clr) | st_set;
  wire [3:0]  samp_idx = (ch_q <= `CH_SAMP_LAST) ? ch_q[3:0] : `SAMP_L_IDX;

  function sc_end_d;
    input [2:0] s;
    input       g;
    sc_end_d = (s == S_DONE) & ~g;
  endfunction

  function gb_end_d;
    input [2:0] s;
    input       g;
    gb_end_d = (s == S_DONE) & g;
  endfunction

  // Registers, scan engine and interrupt flags share one process since both sides write them.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trig_q      <= `TRIG_RST;
      acc_ctl_q   <= `ACC_RST;
      ctl_q       <= `CTL_RST;
      mask_a_q    <= 27'h000_0000;
      mask_b_q    <= 27'h000_0000;
      stat_q      <= 2'h0;
      ien_q       <= 2'h0;
      ring_en_q   <= 1'b0;
      ring_ptr_q  <= 4'h0;
      ring_wrap_q <= 1'b0;
      for (i = 0; i < 12; i = i + 1) samp_q[i] <= `SAMP_RST;
      for (i = 0; i < 27; i = i + 1) res_q[i] <= 16'h0000;
      for (i = 0; i < 16; i = i + 1) ring_q[i] <= 16'h0000;
      state_q        <= S_IDLE;
      grp_q          <= 1'b0;
      pend_b_q       <= 1'b0;
      ch_q           <= 5'h00;
      rep_q          <= 3'h0;
      acc_q          <= 15'h0000;
      scan_mask_q    <= 27'h000_0000;
      conv_start_q   <= 1'b0;
      conv_abort_q   <= 1'b0;
      conv_channel_q <= 5'h00;
      conv_samp_q    <= 8'h00;
      scan_end_q     <= 1'b0;
      gb_end_q       <= 1'b0;
      irq_q          <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      conv_abort_q <= 1'b0;
      scan_end_q   <= st_set[`ST_SCAN_END];
      gb_end_q     <= st_set[`ST_GB_END];
      // A flag set in the same cycle as its clear stays set.
      stat_q <= stat_d;
      irq_q  <= |(stat_d & ien_q);

      // Software writes.
      if (do_write) begin
        case (wr_w)
          `W_TRIG:     trig_q <= wr_val[15:0];
          `W_ACC:      acc_ctl_q <= {wr_val[`ACC_AVG_BIT], 4'h0, wr_val[2:0]};
          `W_CTL:      ctl_q <= {1'b0, wr_val[7:0]};
          `W_MASK_A:   mask_a_q <= wr_val[26:0] & `CH_IMPL;
          `W_MASK_B:   mask_b_q <= wr_val[26:0] & `CH_IMPL;
          `W_IEN:      ien_q <= wr_val[1:0];
          `W_RING_EN:  ring_en_q <= wr_val[0];
          default: begin
            if (wr_w >= `W_SAMP && wr_w <= `W_SAMP_END) begin
              samp_q[wr_so[3:0]] <= wr_val[7:0];
            end
          end
        endcase
      end

      // Scan engine.
      case (state_q)
        S_IDLE: begin
          if (req_a) begin
            state_q <= S_FIND; grp_q <= 1'b0; ch_q <= 5'h00; scan_mask_q <= mask_a_q;
          end else if (req_b || pend_b_q) begin
            state_q <= S_FIND; grp_q <= 1'b1; ch_q <= 5'h00; scan_mask_q <= mask_b_q;
            pend_b_q <= 1'b0;
          end
        end
        S_FIND: begin
          rep_q <= 3'h0;
          acc_q <= 15'h0000;
          if (scan_mask_q[ch_q]) begin
            state_q <= S_CONV;
          end else if (ch_q == `CH_LAST) begin
            state_q <= S_DONE;
          end else begin
            ch_q <= ch_q + 5'h01;
          end
        end
        S_CONV: begin
          conv_start_q   <= 1'b1;
          conv_channel_q <= ch_q;
          conv_samp_q    <= samp_q[samp_idx];
          state_q        <= S_WAIT;
        end
        S_WAIT: begin
          if (conv_done) begin
            acc_q <= acc_q + {3'h0, conv_result};
            if (rep_q == acc_cnt) begin
              state_q <= S_STORE;
            end else begin
              rep_q   <= rep_q + 3'h1;
              state_q <= S_CONV;
            end
          end
        end
        S_STORE: begin
          res_q[ch_q] <= res_val;
          if (ring_en_q) begin
            ring_q[ring_ptr_q] <= res_val;
            ring_ptr_q <= ring_ptr_q + 4'h1;
            if (ring_ptr_q == 4'hF) ring_wrap_q <= 1'b1;
          end
          if (ch_q == `CH_LAST) begin
            state_q <= S_DONE;
          end else begin
            ch_q    <= ch_q + 5'h01;
            state_q <= S_FIND;
          end
        end
        S_DONE: begin
          if (mode == `MODE_CONT && !grp_q) begin
            state_q <= S_FIND; ch_q <= 5'h00; scan_mask_q <= mask_a_q;
          end else begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase

      // A group A request preempts a running group B scan.
      if (grp_mode && ctl_q[`CTL_PRIO_BIT] && grp_q && req_a && state_q != S_IDLE &&
          state_q != S_DONE) begin
        conv_abort_q <= (state_q == S_WAIT);
        state_q      <= S_FIND;
        grp_q        <= 1'b0;
        ch_q         <= 5'h00;
        scan_mask_q  <= mask_a_q;
        pend_b_q     <= ctl_q[`CTL_RESCAN_BIT];
      end

      // Pointer writes by software win over the engine's advance.
      if (do_write && wr_w == `W_RING_PTR) begin
        ring_ptr_q  <= wr_val[3:0];
        ring_wrap_q <= 1'b0;
      end
    end
  end

  // Port drives.
  assign awready               = awready_q;
  assign wready                = wready_q;
  assign bvalid                = bvalid_q;
  assign bresp                 = bresp_q;
  assign arready               = arready_q;
  assign rvalid                = rvalid_q;
  assign rdata                 = rdata_q;
  assign rresp                 = rresp_q;
  assign conv_start            = conv_start_q;
  assign conv_abort            = conv_abort_q;
  assign conv_channel          = conv_channel_q;
  assign conv_sample_states    = conv_samp_q;
  assign selftest_level_select = ctl_q[`CTL_DLVL_MSB:`CTL_DLVL_LSB];
  assign selftest_mode_select  = ctl_q[`CTL_DMODE_BIT];
  assign selftest_enable       = ctl_q[`CTL_DEN_BIT];
  assign scan_end_irq          = scan_end_q;
  assign group_b_scan_end_irq  = gb_end_q;
  assign irq                   = irq_q;

endmodule
`default_nettype wire

// ---- design/adc_trigger_map.vh ----
// Register map, field positions, reset values and codes of the converter control block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ADC_TRIGGER_MAP_VH
`define ADC_TRIGGER_MAP_VH

// Word indices of the registers; byte address is four times the index.
`define W_TRIG     7'h00
`define W_ACC      7'h01
`define W_CTL      7'h02
`define W_MASK_A   7'h03
`define W_MASK_B   7'h04
`define W_STAT     7'h05
`define W_IEN      7'h06
`define W_RING_EN  7'h07
`define W_RING_PTR 7'h08
`define W_ENGINE   7'h09
`define W_SAMP     7'h10
`define W_SAMP_END 7'h1B
`define W_RES      7'h20
`define W_RES_END  7'h3A
`define W_RING     7'h40
`define W_RING_END 7'h4F

// Trigger select fields.
`define TRIG_B_LSB 0
`define TRIG_B_MSB 5
`define TRIG_A_LSB 8
`define TRIG_A_MSB 13

// Accumulation control fields.
`define ACC_CNT_LSB 0
`define ACC_CNT_MSB 2
`define ACC_AVG_BIT 7

// Control register fields.
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 1
`define CTL_PRIO_BIT 2
`define CTL_RESCAN_BIT 3
`define CTL_DLVL_LSB 4
`define CTL_DLVL_MSB 5
`define CTL_DMODE_BIT 6
`define CTL_DEN_BIT 7
`define CTL_SWST_BIT 8

// Interrupt status bits.
`define ST_SCAN_END 0
`define ST_GB_END   1

// Reset values.
`define TRIG_RST 16'h3F3F
`define ACC_RST  8'h00
`define CTL_RST  9'h000
`define SAMP_RST 8'h0D

// Trigger select codes.
`define CODE_EXT       6'h00
`define CODE_TMR_FIRST 6'h01
`define CODE_TMR_LAST  6'h08
`define CODE_LINK      6'h09
`define CODE_NONE      6'h3F

// Scan modes.
`define MODE_SINGLE 2'h0
`define MODE_GROUP  2'h1
`define MODE_CONT   2'h2

// Implemented channel indices 0..8, 16..21, 24..26.
`define CH_IMPL 27'h73F_01FF
`define CH_LAST 5'h1A
`define CH_SAMP_LAST 5'h08
`define SAMP_L_IDX 4'h9

// Bus responses.
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- design/trigger_source_decode.v ----
// Decodes one six-bit start trigger select field into a start pulse.
// Assumes all event inputs are single-cycle pulses on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "adc_trigger_map.vh"
module trigger_source_decode #(
  parameter [0:0] ALLOW_EXT = 1'b0
) (
  // Select field.
  input  wire [5:0] code,
  // Event sources.
  input  wire [7:0] timer_events,
  input  wire       event_link,
  input  wire       ext_edge,
  // Result.
  output reg        start
);

  wire [5:0] tmr_idx = code - `CODE_TMR_FIRST;

  // Only the listed codes pass an event; anything else behaves as no source.
  always @* begin
    start = 1'b0;
    case (code)
      `CODE_EXT:  start = ALLOW_EXT & ext_edge;
      `CODE_LINK: start = event_link;
      `CODE_NONE: start = 1'b0;
      default: begin
        if (code >= `CODE_TMR_FIRST && code <= `CODE_TMR_LAST) begin
          start = timer_events[tmr_idx[2:0]];
        end else begin
          start = 1'b0;
        end
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- verification/conv_core_model.sv ----
// Behavioural analog core that answers each conversion request with a result.
// Assumes one-cycle conv_start pulses on the block clock.
`timescale 1ns/10ps
`default_nettype none
module conv_core_model (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        nrst,
  // Request side.
  input  wire logic        conv_start,
  input  wire logic [4:0]  conv_channel,
  input  wire logic        slow,
  // Answer side.
  output logic             conv_done,
  output logic [11:0]      conv_result
);
  logic [2:0] wait_q;

  // Counts down to the answer; the result bus scrambles whenever it is not valid.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 3'h0;
      conv_done <= 1'b0;
      conv_result <= 12'hFFF;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        wait_q <= slow ? 3'h7 : 3'h1;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
        if (wait_q == 3'h1) begin
          conv_done <= 1'b1;
          conv_result <= 12'h0A0 + {7'h00, conv_channel};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/adc_ctl_asserts.sv ----
// Port-level checks of the converter control block.
// Assumes binding onto the top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module adc_ctl_asserts (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        nrst,
  // Bus.
  input  wire logic        awvalid,
  input  wire logic        awready,
  input  wire logic        wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [1:0]  bresp,
  input  wire logic        arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] rdata,
  // Core and interrupts.
  input  wire logic        conv_start,
  input  wire logic [4:0]  conv_channel,
  input  wire logic        scan_end_irq,
  input  wire logic        group_b_scan_end_irq
);
  localparam logic [31:0] IMPL = 32'h073F_01FF;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Both write halves taken together; the answer must follow shortly.
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence

  a_write_answer: assert property (s_wr_take |-> ##[1:3] bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_take |=> rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (s_rd_take |=> !arready)
    else $error("read address taken twice");
  a_aw_refused: assert property (s_wr_take |=> !awready [*2])
    else $error("write address taken twice");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than a cycle");
  a_channel_impl: assert property (conv_start |-> IMPL[conv_channel])
    else $error("start on channel without result");
  a_scan_pulse: assert property (scan_end_irq |=> !scan_end_irq)
    else $error("scan end longer than a cycle");
  a_gb_pulse: assert property (group_b_scan_end_irq |=> !group_b_scan_end_irq)
    else $error("group b end longer than a cycle");
endmodule
bind adc_trigger_select_control adc_ctl_asserts adc_ctl_asserts_i (
  .clock, .nrst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp,
  .arvalid, .arready, .rvalid, .rready, .rdata, .conv_start, .conv_channel,
  .scan_end_irq, .group_b_scan_end_irq
);
`default_nettype wire

// ---- verification/adc_trigger_select_control_bench.sv ----
// Register-level bench of the converter control block.
// Assumes the core model on the conversion link and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module adc_trigger_select_control_bench;
  logic        clock = 0;
  logic        nrst = 0;
  logic [8:0]  awaddr = 0;
  logic [8:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        slow = 0, pin_n = 1;
  logic [8:0]  ev = 0;
  logic [4:0]  lastch = 0;
  wire logic        awready, wready, bvalid, arready, rvalid, conv_start, conv_done;
  wire logic        scan_end_irq, group_b_scan_end_irq, irq, dmode, den, conv_abort;
  wire logic [1:0]  bresp, rresp, dlvl;
  wire logic [31:0] rdata;
  wire logic [4:0]  conv_channel;
  wire logic [11:0] conv_result;
  int n_mismatch = 0, checks = 0, nst = 0, nse = 0, ngb = 0, nab = 0;

  adc_trigger_select_control adc_trigger_select_control_i (
    .clock, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .timer0_compare_a_event(ev[0]), .timer0_compare_b_event(ev[1]),
    .common_timer_event(ev[2]), .timer0_compare_e_event(ev[3]),
    .timer0_compare_f_event(ev[4]), .timer4_a_event(ev[5]), .timer4_b_event(ev[6]),
    .timer4_a_or_b_event(ev[7]), .event_link_start(ev[8]), .external_start_pin_n(pin_n),
    .conv_start, .conv_abort, .conv_channel, .conv_sample_states(),
    .selftest_level_select(dlvl), .selftest_mode_select(dmode), .selftest_enable(den),
    .conv_done, .conv_result, .scan_end_irq, .group_b_scan_end_irq, .irq);
  conv_core_model conv_core_model_i (
    .clock, .nrst, .conv_start, .conv_channel, .slow, .conv_done, .conv_result);

  // Free-running clock at 200 MHz.
  always #2.5 clock = ~clock;

  // Counts starts, aborts and scan ends so scenarios can compare deltas.
  always @(posedge clock) begin
    if (conv_start) begin
      nst <= nst + 1;
      lastch <= conv_channel;
    end
    if (scan_end_irq) nse <= nse + 1;
    if (group_b_scan_end_irq) ngb <= ngb + 1;
    if (conv_abort) nab <= nab + 1;
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task close_out;
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task lim(input int i);
    if (i >= 300) begin
      n_mismatch++;
      close_out;
    end
  endtask

  // Write halves are released one by one as each is taken.
  task wr(input logic [8:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    chk("bresp", bresp, 0);
    lim(i);
  endtask

  task rd(input logic [8:0] a, input logic [31:0] e, input logic [1:0] r = 0);
    int i;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    chk("rdata", rdata, e);
    chk("rresp", rresp, r);
    lim(i);
  endtask

  task pulse(input logic [8:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 0;
  endtask

  // Waits, bounded, until another scan of either group has ended.
  task wt;
    int i, k0;
    k0 = nse + ngb;
    for (i = 0; i < 300 && nse + ngb == k0; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    lim(i);
  endtask

  // Hang guard; a run this long means a handshake never came.
  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    close_out;
  end

  initial begin
    int c, k, s0;
    int bad[4] = '{'h0A, 'h20, 'h3E, 'h3F};
    repeat (8) @(posedge clock);
    nrst <= 1;
    rd(9'h000, 32'h0000_3F3F);
    rd(9'h004, 32'h0000_0000);
    rd(9'h040, 32'h0000_000D);
    rd(9'h06C, 32'h0000_000D);
    rd(9'h0E8, 32'h0000_0000);
    rd(9'h0A4, 32'h0000_0000, 2);
    rd(9'h0D8, 32'h0000_0000, 2);
    wr(9'h00C, 32'hFFFF_FFFF);
    rd(9'h00C, 32'h073F_01FF);
    wr(9'h00C, 32'h0000_0001);
    wr(9'h020, 32'h0000_0005);
    rd(9'h020, 32'h0000_0005);
    wr(9'h01C, 32'h0000_0001);
    rd(9'h01C, 32'h0000_0001);
    rd(9'h13C, 32'h0000_0000);
    wr(9'h000, 32'h0000_0102);
    rd(9'h000, 32'h0000_0102);
    wr(9'h018, 32'h0000_0001);
    // Each group A code 1..9: a foreign event must not start, its own event must.
    for (c = 1; c < 10; c++) begin
      wr(9'h000, 32'h0000_003F | (c << 8));
      s0 = nst;
      pulse(9'h001 << (c % 9));
      repeat (40) @(posedge clock);
      chk("foreign", nst, s0);
      pulse(9'h001 << (c - 1));
      wt;
      chk("own", nst, s0 + 1);
      chk("irq", irq, 1);
      wr(9'h014, 32'h0000_0001);
      repeat (2) @(posedge clock);
      chk("irqclr", irq, 0);
    end
    // No-source and undefined codes in the group A field ignore every start source; group B is off in single mode.
    for (k = 0; k < 4; k++) begin
      wr(9'h000, (bad[k] << 8) | bad[k]);
      s0 = nst;
      pulse(9'h1FF);
      pin_n <= 0;
      repeat (10) @(posedge clock);
      pin_n <= 1;
      repeat (30) @(posedge clock);
      chk("nosrc", nst, s0);
    end
    wr(9'h000, 32'h0000_003F);
    pin_n <= 0;
    wt;
    pin_n <= 1;
    chk("pin", lastch, 0);
    wr(9'h000, 32'h0000_013F);
    wr(9'h004, 32'h0000_0003);
    slow <= 1;
    s0 = nst;
    pulse(9'h001);
    wt;
    chk("nconv", nst - s0, 4);
    rd(9'h080, 32'h0000_0280);
    wr(9'h004, 32'h0000_0083);
    slow <= 0;
    pulse(9'h001);
    wt;
    rd(9'h080, 32'h0000_00A0);
    wr(9'h004, 32'h0000_0000);
    s0 = nst;
    pulse(9'h001);
    wt;
    chk("single", nst - s0, 1);
    wr(9'h008, 32'h0000_0001);
    wr(9'h010, 32'h0000_0002);
    wr(9'h000, 32'h0000_3F02);
    wr(9'h014, 32'h0000_0003);
    k = nse;
    s0 = ngb;
    pulse(9'h002);
    wt;
    chk("gbend", ngb - s0, 1);
    chk("aend", nse, k);
    chk("gbch", lastch, 1);
    rd(9'h014, 32'h0000_0002);
    wr(9'h000, 32'h0000_0102);
    wr(9'h008, 32'h0000_000D);
    slow <= 1;
    pulse(9'h002);
    repeat (6) @(posedge clock);
    pulse(9'h001);
    wt;
    wt;
    chk("prio", nse - k, 1);
    chk("rescan", ngb - s0, 2);
    chk("abort", nab, 1);
    rd(9'h020, 32'h0000_0015);
    rd(9'h110, 32'h0000_00A1);
    wr(9'h008, 32'h0000_01E0);
    repeat (2) @(posedge clock);
    chk("diag", {den, dmode, dlvl}, 4'hE);
    wt;
    close_out;
  end
endmodule
`default_nettype wire
